// *** design/rst_seq_pkg.sv ***
// package: types, timing constants and states for the reset sequencer
package rst_seq_pkg;

  // ***************************************************************
  // clock
  // ***************************************************************
  localparam int unsigned CLK_HZ = 50_000_000; // system clock rate

  // ***************************************************************
  // sequence times, in nanoseconds as printed (ms x 1e6, us x 1e3)
  // ***************************************************************
  localparam longint unsigned T_DEST_BIST_NS = 64'd7_796_000; // typical
  localparam longint unsigned T_DEST_BIST_MIN_NS = 64'd5_730_000; // least
  localparam longint unsigned T_DEST_NS = 64'd182_000; // typical
  localparam longint unsigned T_DEST_MIN_NS = 64'd111_000; // least
  localparam longint unsigned T_EXT_LONG_NS = 64'd7_793_000; // typical
  localparam longint unsigned T_FUNC_LONG_NS = 64'd179_000; // typical
  localparam longint unsigned T_FUNC_LONG_MIN_NS = 64'd110_000; // least
  localparam longint unsigned T_FUNC_SHORT_NS = 64'd9_000; // typical
  localparam longint unsigned T_BOOT_FIRST_NS = 64'd200_000; // header first
  localparam longint unsigned T_BOOT_LAST_NS = 64'd320_000; // header last

  // cycles from time: typical figures round up, like a least time
  function automatic longint unsigned ns_to_cyc(input longint unsigned ns);
    longint unsigned c;
    c = (ns * CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
    return (c < 64'd1) ? 64'd1 : c;
  endfunction

  localparam int unsigned CYC_DEST_BIST = 32'(ns_to_cyc(T_DEST_BIST_NS));
  localparam int unsigned CYC_DEST_BIST_MIN = 32'(ns_to_cyc(T_DEST_BIST_MIN_NS));
  localparam int unsigned CYC_DEST = 32'(ns_to_cyc(T_DEST_NS));
  localparam int unsigned CYC_DEST_MIN = 32'(ns_to_cyc(T_DEST_MIN_NS));
  localparam int unsigned CYC_EXT_LONG = 32'(ns_to_cyc(T_EXT_LONG_NS));
  localparam int unsigned CYC_FUNC_LONG = 32'(ns_to_cyc(T_FUNC_LONG_NS));
  localparam int unsigned CYC_FUNC_LONG_MIN = 32'(ns_to_cyc(T_FUNC_LONG_MIN_NS));
  localparam int unsigned CYC_FUNC_SHORT = 32'(ns_to_cyc(T_FUNC_SHORT_NS));
  localparam int unsigned CYC_BOOT_FIRST = 32'(ns_to_cyc(T_BOOT_FIRST_NS));
  localparam int unsigned CYC_BOOT_LAST = 32'(ns_to_cyc(T_BOOT_LAST_NS));

  localparam int CNT_W = 20; // wide enough for the longest count
  localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000; // counter after reset
  // final phase grace: pin synchroniser and level filter lag behind the release
  localparam logic [CNT_W-1:0] SYNC_CYC = 20'h00004;

  // ***************************************************************
  // types
  // ***************************************************************
  // reset flavours, one-hot request bits
  typedef struct packed {
    logic dest_bist; // destructive, self-test on
    logic dest; // destructive, self-test off
    logic ext_long; // external long
    logic func_long; // functional long
    logic func_short; // functional short
  } rst_req_t;

  typedef enum logic [2:0] {
    K_DEST_BIST = 3'h0,
    K_DEST = 3'h1,
    K_EXT_LONG = 3'h2,
    K_FUNC_LONG = 3'h3,
    K_FUNC_SHORT = 3'h4
  } rst_kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, // power-up entry; starts the self-test sequence on the next cycle without a request
    S_SEQ = 3'h1, // timed internal sequence
    S_FINAL = 3'h2, // final_reset_phase: wait for pin to rise
    S_BOOT = 3'h3, // boot_assist_firmware running
    S_RUN = 3'h4 // normal_run_mode
  } seq_state_t;

  // status toward the rest of the chip
  typedef struct packed {
    logic in_reset; // internal reset active
    logic boot_busy; // boot firmware window
    logic run_mode; // normal_run_mode reached
    logic first_fetch; // pulse: first instruction fetch
    logic prolonged; // sequence held by outside party
  } seq_stat_t;

endpackage

// *** design/reset_sequence_controller.sv ***
// module: reset sequencer for five reset flavours and the shared reset pin
// Function
// [R1] destructive with self-test: 7.796 ms typical
// [R2] destructive without self-test: 0.182 ms typical
// [R3] external long sequence: 7.793 ms typical
// [R4] functional long sequence: 0.179 ms typical
// [R5] functional short sequence: 0.009 ms typical
// [R6] run mode entry ends sequence, fetches first
// [R7] shared reset line, only pulled low
// [R8] release low drive at sequence end
// [R9] outside low at final phase prolongs
// [R10] functional resets drive pin only if enabled
// [R11] boot firmware 200 us or 320 us
// [R12] boot time follows sequence back to back
// [R13] count clock cycles, phases strictly in order
`timescale 1ns/1ps
module reset_sequence_controller
  import rst_seq_pkg::*;
#(
  parameter int unsigned DEST_BIST_CYC = rst_seq_pkg::CYC_DEST_BIST, // long count
  parameter int unsigned EXT_LONG_CYC = rst_seq_pkg::CYC_EXT_LONG, // long count
  parameter int unsigned DEST_CYC = rst_seq_pkg::CYC_DEST, // long count
  parameter int unsigned FUNC_LONG_CYC = rst_seq_pkg::CYC_FUNC_LONG, // long count
  parameter int unsigned BOOT_FIRST_CYC = rst_seq_pkg::CYC_BOOT_FIRST, // long count
  parameter int unsigned BOOT_LAST_CYC = rst_seq_pkg::CYC_BOOT_LAST // long count
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // reset requests, one-cycle pulses from on-chip sources
  input wire rst_seq_pkg::rst_req_t rst_req,
  // functional_reset_pin_drive_enable for the pending functional source
  input wire logic functional_reset_pin_drive_enable,
  // boot header found at last location (worst-case boot)
  input wire logic boot_hdr_last,
  // shared reset pin, three signals
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  // status
  output rst_seq_pkg::seq_stat_t seq_stat
);
  import rst_seq_pkg::*;

  // ***************************************************************
  // pin synchroniser
  // ***************************************************************
  logic [2:0] pin_sync_r; // three stages; stage 0 only feeds stage 1
  logic [2:0] pin_sync_nxt;
  logic pin_lvl_r; // filtered pin level
  logic pin_lvl_nxt;

  // shift in; level changes when stages 1 and 2 agree
  always_comb
  begin
    pin_sync_nxt = {pin_sync_r[1:0], rst_pin_in};
    pin_lvl_nxt = pin_lvl_r;
    if (pin_sync_r[1] == pin_sync_r[2])
    begin
      pin_lvl_nxt = pin_sync_r[2];
    end
  end

  // register synchroniser; pin assumed high (pulled up) at reset
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_sync_r <= 3'h7;
      pin_lvl_r <= 1'b1;
    end
    else
    begin
      pin_sync_r <= pin_sync_nxt;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  // ***************************************************************
  // sequencer
  // ***************************************************************
  seq_state_t state_r; // current phase
  seq_state_t state_nxt;
  rst_kind_t kind_r; // flavour in progress
  rst_kind_t kind_nxt;
  logic [CNT_W-1:0] cnt_r; // cycles left in phase
  logic [CNT_W-1:0] cnt_nxt;
  logic drive_r; // pulling the pin low
  logic drive_nxt;
  logic fetch_r; // first fetch pulse
  logic fetch_nxt;
  logic prolong_r; // outside held pin in final phase
  logic prolong_nxt;
  logic any_req; // any request this cycle
  rst_kind_t req_kind; // highest-priority request
  logic [CNT_W-1:0] req_len; // length of requested sequence
  logic req_drive; // pin drive for requested sequence

  // priority: destructive beats external beats functional
  always_comb
  begin
    any_req = |rst_req;
    req_kind = K_FUNC_SHORT;
    req_len = CNT_W'(CYC_FUNC_SHORT); // [R5]
    req_drive = functional_reset_pin_drive_enable; // [R10]
    if (rst_req.dest_bist)
    begin
      req_kind = K_DEST_BIST;
      req_len = CNT_W'(DEST_BIST_CYC); // [R1]
      req_drive = 1'b1;
    end
    else if (rst_req.dest)
    begin
      req_kind = K_DEST;
      req_len = CNT_W'(DEST_CYC); // [R2]
      req_drive = 1'b1;
    end
    else if (rst_req.ext_long)
    begin
      req_kind = K_EXT_LONG;
      req_len = CNT_W'(EXT_LONG_CYC); // [R3]
      req_drive = 1'b1;
    end
    else if (rst_req.func_long)
    begin
      req_kind = K_FUNC_LONG;
      req_len = CNT_W'(FUNC_LONG_CYC); // [R4]
      req_drive = functional_reset_pin_drive_enable; // [R10]
    end
  end

  // next phase; a new request restarts from the timed phase
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    drive_nxt = drive_r;
    fetch_nxt = 1'b0;
    prolong_nxt = prolong_r;
    if (any_req)
    begin
      // any request, even during boot or run, restarts the sequence
      state_nxt = S_SEQ;
      kind_nxt = req_kind;
      cnt_nxt = req_len - CNT_W'(1);
      drive_nxt = req_drive;
      prolong_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        S_IDLE:
        begin
          // power-up behaves as destructive reset with self-test
          state_nxt = S_SEQ;
          kind_nxt = K_DEST_BIST;
          cnt_nxt = CNT_W'(DEST_BIST_CYC) - CNT_W'(1); // [R1]
          drive_nxt = 1'b1;
        end
        S_SEQ:
        begin
          // count down whole phase, in order
          if (cnt_r == CNT_RESET) // [R13]
          begin
            state_nxt = S_FINAL;
            drive_nxt = 1'b0; // [R8]
            // reuse the counter so our own release lag is not taken as a hold
            cnt_nxt = SYNC_CYC;
          end
          else
          begin
            cnt_nxt = cnt_r - CNT_W'(1); // [R13]
          end
        end
        S_FINAL:
        begin
          // wait for the line to read high; outside low prolongs
          if (pin_lvl_r) // [R9]
          begin
            state_nxt = S_BOOT;
            cnt_nxt = boot_hdr_last ? CNT_W'(BOOT_LAST_CYC) - CNT_W'(1)
                                    : CNT_W'(BOOT_FIRST_CYC) - CNT_W'(1); // [R11]
          end
          else if (cnt_r == CNT_RESET)
          begin
            // still low after the synchroniser lag: an outside party holds it
            prolong_nxt = 1'b1; // [R9]
          end
          else
          begin
            // pin may still be rising through the synchroniser
            cnt_nxt = cnt_r - CNT_W'(1);
          end
        end
        S_BOOT:
        begin
          // boot firmware follows without overlap
          if (cnt_r == CNT_RESET) // [R12]
          begin
            state_nxt = S_RUN;
            fetch_nxt = 1'b1; // [R6]
          end
          else
          begin
            cnt_nxt = cnt_r - CNT_W'(1);
          end
        end
        S_RUN:
        begin
          // stays here until the next reset request
          state_nxt = S_RUN;
        end
        default:
        begin
          state_nxt = S_IDLE;
        end
      endcase
    end
  end

  // register phase state
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_IDLE;
      kind_r <= K_DEST_BIST;
      cnt_r <= CNT_RESET;
      drive_r <= 1'b1;
      fetch_r <= 1'b0;
      prolong_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      drive_r <= drive_nxt;
      fetch_r <= fetch_nxt;
      prolong_r <= prolong_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  logic oe_n_r; // pin enable, low while pulling low
  logic [4:0] stat_r; // packed status flops

  // open drain: data stays low, only the enable moves, never drive high
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oe_n_r <= 1'b0;
      stat_r <= 5'h10;
    end
    else
    begin
      oe_n_r <= ~drive_nxt; // [R7]
      stat_r <= {state_nxt == S_IDLE || state_nxt == S_SEQ || state_nxt == S_FINAL,
                 state_nxt == S_BOOT, state_nxt == S_RUN, fetch_nxt, prolong_nxt};
    end
  end

  assign rst_pin_out = 1'b0; // constant low data; enable alone drives the line
  assign rst_pin_oe_n = oe_n_r;
  assign seq_stat = seq_stat_t'(stat_r);

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_drive_only_seq: assert property (!oe_n_r |-> state_r == S_SEQ || state_r == S_IDLE)
    else $error("pin driven outside timed phase"); // [R8]
  a_data_low: assert property (rst_pin_out == 1'b0)
    else $error("pin data not low"); // [R7]
  a_func_no_drive: assert property (
    (rst_req.func_short && !(|rst_req[4:1]) && !functional_reset_pin_drive_enable)
    |=> oe_n_r) else $error("functional reset drove pin while disabled"); // [R10]
  a_final_hold: assert property (state_r == S_FINAL && !pin_lvl_r && !any_req
    |=> state_r == S_FINAL) else $error("final phase left while pin low"); // [R9]
  a_boot_after: assert property (state_r == S_FINAL && pin_lvl_r && !any_req
    |=> state_r == S_BOOT) else $error("boot not started after final phase"); // [R12]
  a_fetch_run: assert property (fetch_r |-> state_r == S_RUN && $past(state_r) == S_BOOT)
    else $error("fetch pulse without run entry"); // [R6]
  a_count_down: assert property (state_r == S_SEQ && cnt_r != CNT_RESET && !any_req
    |=> cnt_r == $past(cnt_r) - CNT_W'(1)) else $error("sequence count stalled"); // [R13]
  a_short_len: assert property (rst_req == rst_req_t'(5'h01)
    |=> cnt_r == CNT_W'(CYC_FUNC_SHORT - 1)) else $error("short length wrong"); // [R5]
  a_dest_len: assert property (rst_req == rst_req_t'(5'h08)
    |=> cnt_r == CNT_W'(DEST_CYC) - CNT_W'(1)) else $error("destructive length wrong"); // [R2]
  a_bist_len: assert property (rst_req.dest_bist
    |=> cnt_r == CNT_W'(DEST_BIST_CYC) - CNT_W'(1)) else $error("self-test length wrong"); // [R1]
  a_ext_len: assert property (rst_req == rst_req_t'(5'h04)
    |=> cnt_r == CNT_W'(EXT_LONG_CYC) - CNT_W'(1)) else $error("external length wrong"); // [R3]
  a_flong_len: assert property (rst_req == rst_req_t'(5'h02)
    |=> cnt_r == CNT_W'(FUNC_LONG_CYC) - CNT_W'(1)) else $error("func long length wrong"); // [R4]
  a_boot_len: assert property (state_r == S_FINAL && pin_lvl_r && !any_req && !boot_hdr_last
    |=> cnt_r == CNT_W'(BOOT_FIRST_CYC) - CNT_W'(1)) else $error("boot length wrong"); // [R11]

  c_run_entry: cover property (fetch_r);
  c_prolonged: cover property (prolong_r && state_r == S_BOOT);
  c_func_undriven: cover property (state_r == S_SEQ && kind_r == K_FUNC_SHORT && oe_n_r);
  c_restart_run: cover property (state_r == S_RUN ##1 state_r == S_SEQ);

endmodule // reset_sequence_controller

// *** dv/reset_gen_model.sv ***
// external reset generator model on the shared open-drain reset line
`timescale 1ns/1ps
module reset_gen_model
(
  // clock
  input wire logic sys_clk,
  // bench command: hold the line low for a number of cycles
  input wire logic hold_go,
  input wire logic [15:0] hold_cyc,
  // open-drain drive, low = pull the line low
  output logic gen_oe_n
);
  logic [15:0] left_r; // cycles still to hold low
  initial left_r = 16'h0000;
  // a long hold outlasts the timed phase on purpose, to stretch the final phase
  always @(posedge sys_clk)
    if (hold_go)
      left_r <= hold_cyc;
    else if (left_r != 16'h0000)
      left_r <= left_r - 16'h0001;
  // never drives high, the pull-up owns the high level
  assign gen_oe_n = (left_r == 16'h0000);
endmodule // reset_gen_model

// *** dv/reset_sequence_controller_tb.sv ***
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
module reset_sequence_controller_tb;
  import rst_seq_pkg::*;
  // ***************************************************************
  // setup
  // ***************************************************************
  // small counts keep the run short; short functional count is fixed
  localparam int unsigned NB = 40;
  localparam int unsigned NS = 20;
  localparam int unsigned NF = 32'(T_FUNC_SHORT_NS * CLK_HZ / 64'd1_000_000_000);
  localparam int unsigned BF = 10;
  localparam int unsigned BL = 16;
  typedef struct {int low; int boot; int min_ir; logic prol;} note_t;
  logic sys_clk, reset_n, functional_reset_pin_drive_enable, boot_hdr_last;
  logic rst_pin_in, rst_pin_out, rst_pin_oe_n, gen_oe_n, hold_go, mon_on, prev_ir;
  logic [15:0] hold_cyc;
  rst_req_t rst_req;
  seq_stat_t seq_stat;
  note_t notes[$];
  int num_errors, total_checks, low_c, boot_c, ir_c;
  // wired line: pull-up unless a party pulls low
  assign rst_pin_in = ((!rst_pin_oe_n && !rst_pin_out) || !gen_oe_n) ? 1'b0 : 1'b1;
  reset_sequence_controller #(.DEST_BIST_CYC(NB), .EXT_LONG_CYC(NB), .DEST_CYC(NS),
    .FUNC_LONG_CYC(NS), .BOOT_FIRST_CYC(BF), .BOOT_LAST_CYC(BL)) uut (.sys_clk(sys_clk),
    .reset_n(reset_n), .rst_req(rst_req),
    .functional_reset_pin_drive_enable(functional_reset_pin_drive_enable),
    .boot_hdr_last(boot_hdr_last), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .seq_stat(seq_stat));
  reset_gen_model rgen (.sys_clk(sys_clk), .hold_go(hold_go), .hold_cyc(hold_cyc),
    .gen_oe_n(gen_oe_n));
  // clock, 20 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // bounded wait for run mode
  task automatic wait_run();
    int lim;
    lim = 0;
    while (seq_stat.run_mode !== 1'b1 && lim < 2000)
    begin
      @(negedge sys_clk);
      lim++;
    end
    chk("run_mode wait", 1, lim < 2000);
  endtask
  // pulse one request kind (0 = dest_bist .. 4 = func_short)
  task automatic pulse(input int kind, input int hold);
    @(negedge sys_clk);
    rst_req = rst_req_t'(5'h10 >> kind);
    hold_go = hold > 0;
    hold_cyc = 16'(hold);
    @(negedge sys_clk);
    rst_req = 5'h00;
    hold_go = 1'b0;
  endtask
  // one sequence; pre >= 0 first starts another kind and cuts it short
  task automatic run_seq(input int kind, input logic drv, input logic last, input int hold,
    input int pre);
    note_t n;
    int len;
    len = (kind == 0 || kind == 2) ? NB : ((kind == 4) ? NF : NS);
    n.low = (kind >= 3 && !drv) ? 0 : len;
    n.boot = last ? BL : BF;
    n.min_ir = (hold > len) ? hold : len;
    n.prol = hold > 0;
    functional_reset_pin_drive_enable = drv;
    boot_hdr_last = last;
    if (pre >= 0)
    begin
      pulse(pre, 0);
      repeat (5) @(negedge sys_clk);
    end
    notes.push_back(n);
    pulse(kind, hold);
    wait_run();
    $display("test kind %0d drive %0d last %0d hold %0d done", kind, drv, last, hold);
  endtask
  // ***************************************************************
  // monitor: measures each sequence, compares at the first fetch
  // ***************************************************************
  always @(posedge sys_clk)
  begin
    if (!reset_n || rst_req != 5'h00)
    begin
      low_c = 0;
      boot_c = 0;
      ir_c = 0;
    end
    else
    begin
      low_c += (rst_pin_oe_n === 1'b0);
      boot_c += (seq_stat.boot_busy === 1'b1);
      ir_c += (seq_stat.in_reset === 1'b1);
    end
    // boot window must start on the edge reset ends
    if (mon_on && prev_ir === 1'b1 && seq_stat.in_reset === 1'b0)
      chk("boot follows reset", 1, seq_stat.boot_busy);
    prev_ir = seq_stat.in_reset;
    if (mon_on && seq_stat.first_fetch === 1'b1)
    begin
      chk("note queue", 1, notes.size() > 0);
      if (notes.size() > 0)
      begin
        note_t n;
        n = notes.pop_front();
        chk("pin low cycles", n.low, low_c);
        chk("boot cycles", n.boot, boot_c);
        chk("in_reset span", 1, ir_c >= n.min_ir);
        chk("run at fetch", 1, seq_stat.run_mode);
        chk("prolonged", n.prol, seq_stat.prolonged);
        chk("pin data", 0, rst_pin_out);
      end
    end
  end
  // ***************************************************************
  // main sequence and watchdog
  // ***************************************************************
  initial
  begin
    reset_n = 1'b0;
    rst_req = 5'h00;
    functional_reset_pin_drive_enable = 1'b0;
    boot_hdr_last = 1'b0;
    hold_go = 1'b0;
    hold_cyc = 16'h0000;
    mon_on = 1'b0;
    prev_ir = 1'b0;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(32'h1d46454a));
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    wait_run();
    // let the power-up fetch pulse pass unmeasured; no note belongs to it
    @(negedge sys_clk);
    mon_on = 1'b1;
    for (int k = 0; k < 5; k++)
      run_seq(k, 1'b1, 1'(k), 0, -1);
    run_seq(3, 1'b0, 1'b0, 0, -1);
    run_seq(4, 1'b0, 1'b1, 0, -1);
    for (int k = 0; k < 8; k++)
      run_seq($urandom_range(4, 0), 1'($urandom_range(1, 0)), 1'($urandom_range(1, 0)), 0, -1);
    run_seq(1, 1'b1, 1'b0, 60, -1);
    run_seq(4, 1'b1, 1'b1, 0, 0);
    end_sim();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    chk("watchdog", 1, 0);
    end_sim();
  end
endmodule // reset_sequence_controller_tb
